// *** hdl/vsc_ctl.sv ***
// device state machine, self-test lamp sequencing, cancel and abort frames
`timescale 1ns/1ps
`default_nettype none
module vsc_ctl
#(
   parameter int SLOW_HALF = vsc_pkg::VSC_SLOW_HALF,
   parameter int FAST_HALF = vsc_pkg::VSC_FAST_HALF
)
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic [7:0]          node_id,
   input  wire logic [7:0]          group_num,
   input  wire logic                comm_operational,
   input  wire logic                go_disabled,
   input  wire logic                go_hold,
   input  wire logic                go_active,
   input  wire logic                mode_wr,
   input  wire vsc_pkg::vsc_mode_t  mode_wr_val,
   output logic                     mode_wr_ack,
   output logic                     mode_wr_nak,
   input  wire logic                rx_valid,
   input  wire vsc_pkg::vsc_frame_t rx_frame,
   input  wire logic                st_start,
   input  wire logic                st_starter,
   input  wire logic                st_inject,
   input  wire logic                st_detect,
   input  wire logic                st_release,
   input  wire logic                st_own_done,
   input  wire logic                st_sup_done,
   input  wire logic                st_sup_last,
   input  wire logic                st_section_ok,
   input  wire logic                st_fault,
   input  wire logic [7:0]          st_err_code,
   input  wire logic [7:0]          st_info,
   input  wire logic                st_step,
   input  wire logic [7:0]          st_step_type,
   input  wire logic [7:0]          st_step_val,
   output var  logic                tx_valid_r,
   output var  vsc_pkg::vsc_frame_t tx_frame_r,
   input  wire logic                tx_ready,
   output var  vsc_pkg::vsc_gates_t gates_r,
   output var  vsc_pkg::vsc_mode_t  mode_r,
   output var  logic                self_test_run_r,
   output var  logic                preprog_steer_r,
   output logic                     lamp_green,
   output logic                     lamp_yellow
);
   import vsc_pkg::*;

   // ************************************************************
   // device state machine
   // ************************************************************
   typedef enum logic [1:0] {VSC_S_INIT, VSC_S_DISABLED, VSC_S_HOLD, VSC_S_ACTIVE} vsc_state_t;
   typedef enum logic [1:0] {VSC_T_IDLE, VSC_T_INJECT, VSC_T_WATCH, VSC_T_DETECT} vsc_test_t;

   vsc_state_t  state_r;
   vsc_test_t   test_r;
   vsc_lamp_t   pattern;
   logic        slow;
   logic        fast;
   logic        cancel_hit;
   logic        abort_hit;
   logic        st_running;
   logic        fail_req;
   logic        pass_req;
   logic        own_done_r;
   logic        sup_done_r;

   // cancel: own cmd id, node and group match, type cancel, full length
   assign cancel_hit = rx_valid && rx_frame.id == VSC_ID_CMD
                       && rx_frame.len == VSC_LEN_CANCEL && rx_frame.b0 == node_id
                       && rx_frame.b1 == group_num && rx_frame.b2 == VSC_CMD_CANCEL;
   // abort from any node in the section
   assign abort_hit  = rx_valid && rx_frame.id == VSC_ID_RESULT
                       && rx_frame.len == VSC_LEN_RESULT && rx_frame.b1 == VSC_RES_FAIL;
   assign st_running = state_r == VSC_S_ACTIVE && mode_r == VSC_MODE_SELFTEST;
   assign fail_req   = st_running && self_test_run_r && st_fault;
   assign pass_req   = st_running && self_test_run_r && st_starter && st_section_ok;

   // state transitions; abort and cancel have priority over master requests
   // an abort frame disables every node past init; init still waits for the link
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_r <= VSC_S_INIT;
      else if ((st_running && (cancel_hit || fail_req))
               || (abort_hit && state_r != VSC_S_INIT))
         state_r <= VSC_S_DISABLED;
      else
      begin
         unique case (state_r)
            VSC_S_INIT:
               if (go_disabled && comm_operational)
                  state_r <= VSC_S_DISABLED;
            VSC_S_DISABLED:
               if (go_hold)
                  state_r <= VSC_S_HOLD;
            VSC_S_HOLD:
               if (go_active)
                  state_r <= VSC_S_ACTIVE;
               else if (go_disabled)
                  state_r <= VSC_S_DISABLED;
            VSC_S_ACTIVE:
               if (go_hold)
                  state_r <= VSC_S_HOLD;
               else if (go_disabled)
                  state_r <= VSC_S_DISABLED;
         endcase
      end
   end

   // mode object: writable only in hold
   assign mode_wr_ack = mode_wr && state_r == VSC_S_HOLD;
   assign mode_wr_nak = mode_wr && state_r != VSC_S_HOLD;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mode_r <= VSC_MODE_HAND;
      else if (mode_wr_ack)
         mode_r <= mode_wr_val;
   end

   // ************************************************************
   // feature gates per state and mode
   // ************************************************************
   function automatic vsc_gates_t gates_of(vsc_state_t s, vsc_mode_t m);
      vsc_gates_t g;
      g = '0;
      unique case (s)
         VSC_S_INIT:
         begin
            g.cmp_self = 1'b1;
            g.nbr_mon  = 1'b1;
         end
         VSC_S_DISABLED:
         begin
            g.tx_actual = 1'b1;
            g.cmp_self  = 1'b1;
         end
         VSC_S_HOLD:
         begin
            g.safety_sw  = 1'b1;
            g.guard_nbr  = 1'b1;
            g.tx_actual  = 1'b1;
            g.cmp_self   = 1'b1;
            g.cmp_nbr_ad = (m == VSC_MODE_FULL);
            g.cmp_nbr_sp = (m == VSC_MODE_FULL);
         end
         VSC_S_ACTIVE:
         begin
            g.safety_sw  = 1'b1;
            g.guard_nbr  = 1'b1;
            g.tx_actual  = 1'b1;
            g.cmp_nbr_ad = 1'b1;
            if (m != VSC_MODE_HAND)
            begin
               g.driver     = 1'b1;
               g.guard_setp = 1'b1;
               g.cmp_self   = 1'b1;
               g.cmp_nbr_sp = 1'b1;
               g.spool_ctl  = (m == VSC_MODE_FULL);
            end
         end
      endcase
      return g;
   endfunction

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         gates_r <= '0;
      else
         gates_r <= gates_of(state_r, mode_r);
   end

   // preprogrammed steering only while a self-test run is going
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         preprog_steer_r <= 1'b0;
      else
         preprog_steer_r <= st_running && self_test_run_r;
   end

   // ************************************************************
   // self-test lamp sequencing
   // ************************************************************
   // run flag: start sets, cancel, abort, fault and full completion clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         self_test_run_r <= 1'b0;
      else if (!st_running || cancel_hit || abort_hit || fail_req)
         self_test_run_r <= 1'b0;
      else if (st_start)
         self_test_run_r <= 1'b1;
      else if (own_done_r && (sup_done_r || st_sup_last) && test_r == VSC_T_IDLE)
         self_test_run_r <= 1'b0;
   end

   // done flags; the set wins over the start clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         own_done_r <= 1'b0;
         sup_done_r <= 1'b0;
      end
      else
      begin
         own_done_r <= st_own_done || (own_done_r && !st_start);
         sup_done_r <= st_sup_done || (sup_done_r && !st_start);
      end
   end

   // injector and supervisor phases; release of the second supply ends detection
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         test_r <= VSC_T_IDLE;
      else if (!self_test_run_r)
         test_r <= VSC_T_IDLE;
      else
      begin
         unique case (test_r)
            VSC_T_IDLE:
               if (st_inject)
                  test_r <= VSC_T_INJECT;
               else if (st_detect)
                  test_r <= VSC_T_DETECT;
            VSC_T_INJECT:
               if (st_own_done)
                  test_r <= VSC_T_IDLE;
            VSC_T_DETECT:
               if (st_release)
                  test_r <= VSC_T_WATCH;
            VSC_T_WATCH:
               if (st_detect)
                  test_r <= VSC_T_DETECT;
               else if (st_sup_done || st_sup_last)
                  test_r <= VSC_T_IDLE;
         endcase
      end
   end

   always_comb
   begin
      pattern = VSC_LAMP_STEADY;
      if (self_test_run_r)
      begin
         unique case (test_r)
            VSC_T_IDLE:   pattern = VSC_LAMP_G1;
            VSC_T_INJECT: pattern = VSC_LAMP_G4;
            VSC_T_WATCH:  pattern = VSC_LAMP_G4;
            VSC_T_DETECT: pattern = VSC_LAMP_Y4;
         endcase
      end
   end

   vsc_blink #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_blink
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .slow_r  (slow),
      .fast_r  (fast)
   );

   vsc_lamp u_lamp
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .pattern  (pattern),
      .slow     (slow),
      .fast     (fast),
      .green_r  (lamp_green),
      .yellow_r (lamp_yellow)
   );

   // ************************************************************
   // transmit frames: abort, pass result, step messages
   // ************************************************************
   // one frame slot; a request that comes while the slot is still held and not taken is dropped
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_valid_r <= 1'b0;
         tx_frame_r <= '0;
      end
      else if (tx_valid_r && !tx_ready)
         tx_valid_r <= 1'b1;
      else if (fail_req)
      begin
         tx_valid_r <= 1'b1;
         tx_frame_r <= '{VSC_ID_RESULT, VSC_LEN_RESULT, node_id, VSC_RES_FAIL,
                         st_err_code, 8'h00};
      end
      else if (pass_req)
      begin
         tx_valid_r <= 1'b1;
         tx_frame_r <= '{VSC_ID_RESULT, VSC_LEN_RESULT, node_id, VSC_RES_PASS,
                         st_info, 8'h00};
      end
      else if (st_running && self_test_run_r && st_step)
      begin
         tx_valid_r <= 1'b1; // sent at once, no sync is awaited
         tx_frame_r <= '{11'(VSC_ID_STEP + 11'(node_id)), VSC_LEN_STEP, st_step_type,
                         st_step_val, 8'h00, 8'h00};
      end
      else
         tx_valid_r <= 1'b0;
   end

   // ************************************************************
   // checks
   // ************************************************************
   AST_RESET_INIT: assert property (@(posedge clk) disable iff (sys_rst)
      state_r == VSC_S_INIT |=> gates_r.cmp_self && gates_r.nbr_mon && !gates_r.safety_sw
      && !gates_r.driver && !gates_r.tx_actual && !gates_r.spool_ctl)
      else $error("power-up gates wrong");
   AST_DISABLED_NEEDS_OP: assert property (@(posedge clk) disable iff (sys_rst)
      ($past(state_r) == VSC_S_INIT && state_r == VSC_S_DISABLED) |-> $past(comm_operational))
      else $error("disabled entered without operational link");
   AST_CANCEL_DISABLES: assert property (@(posedge clk) disable iff (sys_rst)
      (st_running && cancel_hit) |=> state_r == VSC_S_DISABLED && !self_test_run_r)
      else $error("cancel did not disable");
   AST_ABORT_DISABLES: assert property (@(posedge clk) disable iff (sys_rst)
      (abort_hit && state_r != VSC_S_INIT) |=> state_r == VSC_S_DISABLED)
      else $error("abort frame did not disable");
   AST_FAIL_FRAME: assert property (@(posedge clk) disable iff (sys_rst)
      fail_req && !(tx_valid_r && !tx_ready) |=> tx_valid_r && tx_frame_r.id == VSC_ID_RESULT
      && tx_frame_r.b1 == VSC_RES_FAIL && tx_frame_r.b0 == node_id)
      else $error("abort frame missing");
   AST_MODE_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
      state_r == VSC_S_ACTIVE |=> $stable(mode_r))
      else $error("mode changed while active");
   AST_HAND_GATES: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == VSC_S_ACTIVE && mode_r == VSC_MODE_HAND && $stable(state_r)) |=>
      !gates_r.driver && !gates_r.cmp_self && gates_r.cmp_nbr_ad && gates_r.safety_sw)
      else $error("hand mode gates wrong");
   AST_FULL_GATES: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == VSC_S_ACTIVE && mode_r == VSC_MODE_FULL) |=> gates_r.spool_ctl
      || $past(state_r, 1) != VSC_S_ACTIVE)
      else $error("full mode lacks spool control");
   AST_DETECT_YELLOW: assert property (@(posedge clk) disable iff (sys_rst)
      (self_test_run_r && test_r == VSC_T_DETECT) |=> !lamp_green)
      else $error("detect phase not yellow");
endmodule
`default_nettype wire

// *** hdl/vsc_pkg.sv ***
// package: constants, enums and frame structs for the valve state and self-test control
package vsc_pkg;
   // frame identifiers and fields
   localparam logic [10:0] VSC_ID_CMD      = 11'h281;
   localparam logic [10:0] VSC_ID_RESULT   = 11'h282;
   localparam logic [10:0] VSC_ID_STEP     = 11'h290;
   localparam logic [3:0]  VSC_LEN_CANCEL  = 4'h4;
   localparam logic [3:0]  VSC_LEN_RESULT  = 4'h3;
   localparam logic [3:0]  VSC_LEN_STEP    = 4'h2;
   localparam logic [7:0]  VSC_CMD_CANCEL  = 8'h00;
   localparam logic [7:0]  VSC_RES_FAIL    = 8'h00;
   localparam logic [7:0]  VSC_RES_PASS    = 8'hff;
   localparam logic [15:0] VSC_OBJ_MODE    = 16'h6042;
   // lamp timing
   localparam int          VSC_CLK_HZ      = 50_000_000;
   localparam int          VSC_SLOW_HZ     = 1;
   localparam int          VSC_FAST_HZ     = 4;
   // half period counts, rounded down so the blink is never slower than named
   localparam int          VSC_SLOW_HALF   = VSC_CLK_HZ / (2 * VSC_SLOW_HZ);
   localparam int          VSC_FAST_HALF   = VSC_CLK_HZ / (2 * VSC_FAST_HZ);

   typedef enum logic [1:0] {VSC_MODE_SELFTEST, VSC_MODE_HAND, VSC_MODE_FULL} vsc_mode_t;
   typedef enum logic [1:0] {VSC_LAMP_STEADY, VSC_LAMP_G1, VSC_LAMP_G4, VSC_LAMP_Y4} vsc_lamp_t;

   // received or transmitted frame
   typedef struct packed {
      logic [10:0] id;
      logic [3:0]  len;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [7:0]  b3;
   } vsc_frame_t;

   // feature gates driven by the device state
   typedef struct packed {
      logic safety_sw;
      logic driver;
      logic guard_nbr;
      logic guard_setp;
      logic tx_actual;
      logic spool_ctl;
      logic cmp_self;
      logic cmp_nbr_ad;
      logic cmp_nbr_sp;
      logic nbr_mon;
   } vsc_gates_t;
endpackage

// *** hdl/vsc_blink.sv ***
// lamp blink generator: 1 Hz and 4 Hz square waves from the system clock
`timescale 1ns/1ps
`default_nettype none
module vsc_blink
#(
   parameter int SLOW_HALF = vsc_pkg::VSC_SLOW_HALF,
   parameter int FAST_HALF = vsc_pkg::VSC_FAST_HALF
)
(
   input  wire logic clk,
   input  wire logic sys_rst,
   output var  logic slow_r,
   output var  logic fast_r
);
   import vsc_pkg::*;

   logic [31:0] slow_cnt_r;
   logic [31:0] fast_cnt_r;

   // slow wave divider
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slow_cnt_r <= 32'h0;
         slow_r     <= 1'b0;
      end
      else if (slow_cnt_r >= 32'(SLOW_HALF - 1))
      begin
         slow_cnt_r <= 32'h0;
         slow_r     <= ~slow_r;
      end
      else
         slow_cnt_r <= slow_cnt_r + 32'h1;
   end

   // fast wave divider
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fast_cnt_r <= 32'h0;
         fast_r     <= 1'b0;
      end
      else if (fast_cnt_r >= 32'(FAST_HALF - 1))
      begin
         fast_cnt_r <= 32'h0;
         fast_r     <= ~fast_r;
      end
      else
         fast_cnt_r <= fast_cnt_r + 32'h1;
   end

   // the toggle must follow a full half period
   AST_SLOW_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst)
      (slow_cnt_r != 32'(SLOW_HALF - 1)) |=> $stable(slow_r))
      else $error("slow blink toggled early");
endmodule
`default_nettype wire

// *** hdl/vsc_lamp.sv ***
// lamp driver: maps a pattern code to green and yellow outputs
`timescale 1ns/1ps
`default_nettype none
module vsc_lamp
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire vsc_pkg::vsc_lamp_t pattern,
   input  wire logic             slow,
   input  wire logic             fast,
   output var  logic             green_r,
   output var  logic             yellow_r
);
   import vsc_pkg::*;

   // registered so the lamp pins never glitch on pattern changes
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         green_r  <= 1'b0;
         yellow_r <= 1'b0;
      end
      else
      begin
         unique case (pattern)
            VSC_LAMP_STEADY:
            begin
               green_r  <= 1'b1;
               yellow_r <= 1'b0;
            end
            VSC_LAMP_G1:
            begin
               green_r  <= slow;
               yellow_r <= 1'b0;
            end
            VSC_LAMP_G4:
            begin
               green_r  <= fast;
               yellow_r <= 1'b0;
            end
            default:
            begin
               green_r  <= 1'b0;
               yellow_r <= fast;
            end
         endcase
      end
   end

   AST_YELLOW_ONLY_Y4: assert property (@(posedge clk) disable iff (sys_rst)
      yellow_r |-> $past(pattern) == VSC_LAMP_Y4)
      else $error("yellow lamp outside yellow pattern");
endmodule
`default_nettype wire

// *** dv/vsc_far.sv ***
// far-end model: bus master and neighbour nodes facing the controller
`timescale 1ns/1ps
`default_nettype none
module vsc_far
(
   input  wire logic                clk,
   input  wire logic                tx_valid,
   input  wire vsc_pkg::vsc_frame_t tx_frame,
   output var  logic                tx_ready,
   output var  logic                rx_valid,
   output var  vsc_pkg::vsc_frame_t rx_frame,
   input  wire logic [3:0]          stall
);
   import vsc_pkg::*;
   vsc_frame_t got = '0;
   int         n_got = 0;
   int         wait_n = 0;
   initial
   begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_frame = '0;
   end
   // take a frame after stall cycles; a slow master must not lose it
   always @(posedge clk)
   begin
      tx_ready <= 1'b0;
      if (tx_valid && tx_ready)
      begin
         got <= tx_frame;
         n_got <= n_got + 1;
      end
      else if (tx_valid && wait_n >= int'(stall))
         tx_ready <= 1'b1;
      wait_n <= (tx_valid && !tx_ready) ? wait_n + 1 : 0;
   end
   // one-cycle frame; bytes inverted after so stale data never looks valid
   task automatic send(input vsc_frame_t f);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_frame <= f;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_frame <= ~f;
   endtask
endmodule
`default_nettype wire

// *** dv/tb_vsc_ctl.sv ***
// testbench for the valve state and self-test controller
`timescale 1ns/1ps
`default_nettype none
module tb_vsc_ctl;
   import vsc_pkg::*;
   // ****************
   // signals
   // ****************
   logic        clk, sys_rst, comm, ack, nak, txv, trdy, rxv, run, pst, lg, ly;
   logic [12:0] p;
   logic [7:0]  err;
   logic [3:0]  stall;
   logic        starter, sup_last;
   vsc_mode_t   mwv, md;
   vsc_frame_t  txf, rxf;
   vsc_gates_t  g;
   int          failures, total_checks;
   // short blink halves keep lamp checks to a few dozen cycles
   vsc_ctl #(.SLOW_HALF(4), .FAST_HALF(1)) i_vsc_ctl (.clk(clk), .sys_rst(sys_rst),
      .node_id(8'h10), .group_num(8'h01), .comm_operational(comm),
      .go_disabled(p[0]), .go_hold(p[1]), .go_active(p[2]), .mode_wr(p[12]),
      .mode_wr_val(mwv), .mode_wr_ack(ack), .mode_wr_nak(nak), .rx_valid(rxv),
      .rx_frame(rxf), .st_start(p[3]), .st_starter(starter), .st_inject(p[4]),
      .st_detect(p[5]), .st_release(p[6]), .st_own_done(p[7]), .st_sup_done(p[8]),
      .st_sup_last(sup_last), .st_section_ok(p[9]), .st_fault(p[10]), .st_err_code(err),
      .st_info(8'h5a), .st_step(p[11]), .st_step_type(8'h02), .st_step_val(8'h01),
      .tx_valid_r(txv), .tx_frame_r(txf), .tx_ready(trdy), .gates_r(g), .mode_r(md),
      .self_test_run_r(run), .preprog_steer_r(pst), .lamp_green(lg), .lamp_yellow(ly));
   vsc_far i_vsc_far (.clk(clk), .tx_valid(txv), .tx_frame(txf), .tx_ready(trdy),
      .rx_valid(rxv), .rx_frame(rxf), .stall(stall));
   // ****************
   // helpers
   // ****************
   task chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task pu(input int i);
      p <= 13'h1 << i;
      @(posedge clk);
      p <= '0;
      repeat (3) @(posedge clk);
   endtask
   // pulse then wait bounded for the far end to take one frame
   task ptx(input int i);
      int n0;
      n0 = i_vsc_far.n_got;
      pu(i);
      repeat (60) if (i_vsc_far.n_got == n0) @(posedge clk);
   endtask
   task mw(input vsc_mode_t m, input logic a);
      mwv <= m;
      p <= 13'h1000;
      @(negedge clk);
      chk({ack, nak}, {a, !a});
      @(posedge clk);
      p <= '0;
      repeat (3) @(posedge clk);
   endtask
   task to_mode(input vsc_mode_t m);
      sys_rst <= 1'b1;
      comm <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      pu(0);
      pu(1);
      mw(m, 1'b1);
      pu(2);
   endtask
   // lamp edges seen at falling edges over 32 cycles; 0 steady, 1 slow, 2 fast, 3 yellow
   task lamp(input int k);
      int ng, ny;
      logic og, oy, ok;
      ng = 0;
      ny = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      og = lg;
      oy = ly;
      repeat (32)
      begin
         @(negedge clk);
         ng += int'(lg !== og);
         ny += int'(ly !== oy);
         og = lg;
         oy = ly;
      end
      @(posedge clk);
      case (k)
         0: ok = ng == 0 && ny == 0 && lg === 1'b1;
         1: ok = ng >= 6 && ng <= 10 && ny == 0;
         2: ok = ng >= 14 && ny == 0;
         default: ok = ny >= 14 && ng == 0;
      endcase
      chk(ok, 1'b1);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task t_states;
      repeat (2) @(posedge clk);
      chk(g, 10'h009);
      pu(0);
      chk(g, 10'h009);
      comm <= 1'b1;
      pu(0);
      chk(g[9:3], 7'h05);
      pu(1);
      chk(g[9:1], 9'h154);
      mw(VSC_MODE_FULL, 1'b1);
      chk(g[9:1], 9'h157);
      pu(2);
      chk(g[9:1], 9'h1ff);
      mw(VSC_MODE_HAND, 1'b0);
      chk(md, VSC_MODE_FULL);
      to_mode(VSC_MODE_HAND);
      chk(g[9:1], 9'h152);
      $display("t_states done");
   endtask
   task t_self;
      to_mode(VSC_MODE_SELFTEST);
      chk({g[9:6], g[3:1]}, 7'h7f);
      lamp(0);
      pu(3);
      chk({run, pst}, 2'b11);
      lamp(1);
      pu(4);
      lamp(2);
      pu(7);
      lamp(1);
      pu(5);
      lamp(3);
      pu(6);
      lamp(2);
      stall <= 4'h2;
      ptx(11);
      chk(i_vsc_far.got[46:16], {VSC_ID_STEP + 11'h10, VSC_LEN_STEP, 16'h0201});
      starter <= 1'b0;
      pu(9);
      chk(txv, 1'b0);
      starter <= 1'b1;
      ptx(9);
      chk(i_vsc_far.got[46:8], {VSC_ID_RESULT, VSC_LEN_RESULT, 8'h10, VSC_RES_PASS, 8'h5a});
      pu(8);
      lamp(0);
      $display("t_self done");
   endtask
   task t_fault;
      to_mode(VSC_MODE_SELFTEST);
      pu(3);
      pu(7);
      pu(5);
      sup_last <= 1'b1;
      pu(6);
      chk(run, 1'b0);
      sup_last <= 1'b0;
      pu(3);
      stall <= 4'h3;
      ptx(10);
      chk(i_vsc_far.got[46:8], {VSC_ID_RESULT, VSC_LEN_RESULT, 8'h10, VSC_RES_FAIL, err});
      chk({run, g[9:3]}, 8'h05);
      $display("t_fault done");
   endtask
   task t_cancel;
      to_mode(VSC_MODE_SELFTEST);
      pu(3);
      i_vsc_far.send({VSC_ID_CMD, VSC_LEN_CANCEL, 16'h1002, VSC_CMD_CANCEL, 8'h00});
      repeat (3) @(posedge clk);
      chk(run, 1'b1);
      i_vsc_far.send({VSC_ID_CMD, VSC_LEN_CANCEL, 16'h1001, VSC_CMD_CANCEL, 8'h00});
      repeat (3) @(posedge clk);
      chk({run, g[9:3]}, 8'h05);
      to_mode(VSC_MODE_FULL);
      i_vsc_far.send({VSC_ID_RESULT, VSC_LEN_RESULT, 8'h12, VSC_RES_FAIL, 16'h2b00});
      repeat (3) @(posedge clk);
      chk(g[9:3], 7'h05);
      $display("t_cancel done");
   endtask
   // ****************
   // clock, sequence, watchdog
   // ****************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      sys_rst = 1'b1;
      comm = 1'b0;
      p = '0;
      mwv = VSC_MODE_HAND;
      err = 8'h2b;
      stall = 4'h0;
      starter = 1'b1;
      sup_last = 1'b0;
      failures = 0;
      total_checks = 0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_states;
      t_self;
      t_fault;
      t_cancel;
      end_of_test;
   end
   // the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      failures++;
      end_of_test;
   end
endmodule
`default_nettype wire
